// ### hw/pm_defs.vh
// Purpose: constants of the suspend/sleep power controller
// Assumes: apb byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef PM_DEFS_VH
`define PM_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define PM_OFF_CFG 12'h000
`define PM_OFF_DCDC 12'h004
`define PM_OFF_STAT 12'h008

// ****************************************
// power_mode_config fields
// ****************************************
`define PM_BIT_SLEEP 7
`define PM_BIT_SUSPEND 6
`define PM_BIT_CLEAR 5
`define PM_BIT_RSTWAKE 4
`define PM_SRC_HI 3
`define PM_SRC_CMP 0

// ****************************************
// dcdc_config fields
// ****************************************
`define PM_BIT_FLOAT 1
`define PM_DCDC_RST 1'b0

// ****************************************
// reset values and timing
// ****************************************
`define PM_EN_RST 4'h0
`define PM_WAKE_CYCLES 2'h2

`endif

// ### hw/power_mode_ctrl.v
// Purpose: suspend and sleep entry, wake-up and wake flags
// Assumes: always-powered clk at 10 MHz, apb slave, pins async
// Notes: apb answers in the first access cycle
//
// Summary of operation
// - suspend gates clock, stops internal oscillators
// - logic halted until enabled wake source
// - flags read zero two cycles after wake
// - four wake sources each individually enabled
// - reset pin low at one clk edge ends suspend; shorter glitches are not sampled
// - sleep cuts regulator, ram on supply pin
// - digital outputs hold state during sleep
// - digital inputs wake sleep through port match
// - analog rail tied to battery unless float
// - sleep keeps ram, registers and program state
// - comparator wake in sleep needs two-cell mode
// - reset pin falling edge always wakes
// - writing one enables a wake source
// - flags latch always, enabled or not
// - entry refused while enabled flag set
// - bit 7 selects sleep, bit 6 suspend
// - reset wake flag reads one after fall
//
// Chosen here: the APB slave port and the register addresses.
`default_nettype none
`include "pm_defs.vh"
module power_mode_ctrl (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rtc_osc_fail,
  input wire rtc_alarm,
  input wire port_match,
  input wire cmp_out,
  input wire rst_pin_n,
  input wire two_cell_mode,
  output reg clk_gate_off,
  output reg osc_off,
  output reg core_halt,
  output reg regulator_off,
  output reg ram_on_supply_pin,
  output reg analog_tie_vbat,
  output reg analog_float,
  output reg io_hold,
  output reg state_retain
);

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_RUN = 2'b00;
  localparam [1:0] ST_SUSPEND = 2'b01;
  localparam [1:0] ST_SLEEP = 2'b10;
  localparam [1:0] ST_WAKE = 2'b11;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [3:0] enable_reg;
  reg [3:0] enable_next;
  reg float_reg;
  reg [1:0] wake_cnt_reg;
  reg [1:0] wake_cnt_next;
  reg refused_reg;
  reg rst_prev_reg;
  reg cmp_prev_reg;

  // ****************************************
  // pin synchronisers
  // ****************************************
  wire [4:0] pins_s;

  // reset pin enters inverted so an idle pin matches the cleared stages
  sync2 #(
    .WIDTH(5)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({~rst_pin_n, cmp_out, port_match, rtc_alarm, rtc_osc_fail}),
    .q(pins_s)
  );

  // ****************************************
  // event detection
  // ****************************************
  wire rst_fall;
  wire cmp_rise;
  wire [4:0] events;

  assign rst_fall = pins_s[4] & ~rst_prev_reg;
  assign cmp_rise = pins_s[3] & ~cmp_prev_reg;
  assign events = {rst_fall, pins_s[0], pins_s[1], pins_s[2], cmp_rise};

  always @(posedge clk) begin
    if (!rst_n) begin
      rst_prev_reg <= 1'b0;
      cmp_prev_reg <= 1'b0;
    end else begin
      rst_prev_reg <= pins_s[4];
      cmp_prev_reg <= pins_s[3];
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  wire setup;
  wire access;
  wire wr;
  wire hit_cfg;
  wire hit_dcdc;
  wire hit_stat;
  wire mapped;
  wire clr;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign hit_cfg = (paddr == `PM_OFF_CFG);
  assign hit_dcdc = (paddr == `PM_OFF_DCDC);
  assign hit_stat = (paddr == `PM_OFF_STAT);
  assign mapped = hit_cfg | hit_dcdc | hit_stat;
  assign clr = wr & hit_cfg & pwdata[`PM_BIT_CLEAR];

  // ****************************************
  // wake flags
  // ****************************************
  wire [4:0] flags;

  wake_flags #(
    .N(5)
  ) u_flags (
    .clk(clk),
    .rst_n(rst_n),
    .set(events),
    .clear(clr),
    .flags(flags)
  );

  // ****************************************
  // entry check and wake condition
  // ****************************************
  wire go_sleep;
  wire go_suspend;
  wire [3:0] new_en;
  wire [3:0] live_flags;
  wire blocked;
  wire [3:0] src_en;
  wire wake;

  assign go_sleep = wr & hit_cfg & pwdata[`PM_BIT_SLEEP];
  assign go_suspend = wr & hit_cfg & pwdata[`PM_BIT_SUSPEND];
  assign new_en = pwdata[`PM_SRC_HI:`PM_SRC_CMP];
  assign live_flags = clr ? events[3:0] : (flags[3:0] | events[3:0]);
  assign blocked = |(live_flags & new_en);
  // comparator source counts in sleep only in two-cell mode
  assign src_en = (state_reg == ST_SLEEP) ?
    {enable_reg[3:1], enable_reg[0] & two_cell_mode} : enable_reg;
  assign wake = |((flags[3:0] | events[3:0]) & src_en) | events[4];

  // ****************************************
  // power state machine
  // ****************************************
  always @* begin
    state_next = state_reg;
    enable_next = enable_reg;
    wake_cnt_next = wake_cnt_reg;
    case (state_reg)
      ST_RUN: begin
        if (wr & hit_cfg) begin
          enable_next = new_en;
        end
        if ((go_sleep | go_suspend) & ~blocked) begin
          state_next = go_sleep ? ST_SLEEP : ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (wake) begin
          state_next = ST_WAKE;
          wake_cnt_next = `PM_WAKE_CYCLES;
        end
      end
      ST_SLEEP: begin
        if (wake) begin
          state_next = ST_WAKE;
          wake_cnt_next = `PM_WAKE_CYCLES;
        end
      end
      ST_WAKE: begin
        wake_cnt_next = wake_cnt_reg - 2'h1;
        if (wake_cnt_reg == 2'h1) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      enable_reg <= `PM_EN_RST;
      wake_cnt_reg <= 2'h0;
      float_reg <= `PM_DCDC_RST;
      refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      enable_reg <= enable_next;
      wake_cnt_reg <= wake_cnt_next;
      if (wr & hit_dcdc) begin
        float_reg <= pwdata[`PM_BIT_FLOAT];
      end
      if ((go_sleep | go_suspend) & (state_reg == ST_RUN)) begin
        refused_reg <= blocked;
      end
    end
  end

  // ****************************************
  // power control outputs
  // ****************************************
  wire nx_low;
  wire nx_sleep;

  assign nx_low = (state_next == ST_SUSPEND) | (state_next == ST_SLEEP);
  assign nx_sleep = (state_next == ST_SLEEP);

  always @(posedge clk) begin
    if (!rst_n) begin
      clk_gate_off <= 1'b0;
      osc_off <= 1'b0;
      core_halt <= 1'b0;
      regulator_off <= 1'b0;
      ram_on_supply_pin <= 1'b0;
      analog_tie_vbat <= 1'b0;
      analog_float <= 1'b0;
      io_hold <= 1'b0;
      state_retain <= 1'b0;
    end else begin
      clk_gate_off <= nx_low;
      osc_off <= nx_low;
      core_halt <= nx_low;
      regulator_off <= nx_sleep;
      ram_on_supply_pin <= nx_sleep;
      analog_tie_vbat <= nx_sleep & ~float_reg;
      analog_float <= nx_sleep & float_reg;
      io_hold <= nx_sleep;
      state_retain <= nx_sleep;
    end
  end

  // ****************************************
  // apb read and answer
  // ****************************************
  reg [31:0] rdata;
  wire [4:0] flag_view;

  // read data is captured one edge early, so look at the access cycle's state
  assign flag_view = (state_next == ST_WAKE) ? 5'h00 : flags;

  always @* begin
    rdata = 32'h00000000;
    if (hit_cfg) begin
      rdata = {27'h0000000, flag_view};
    end else if (hit_dcdc) begin
      rdata = {30'h00000000, float_reg, 1'b0};
    end else if (hit_stat) begin
      rdata = {29'h00000000, refused_reg, state_reg};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rdata : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ### hw/sync2.v
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second
`default_nettype none
module sync2 #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire rst_n,
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// ### hw/wake_flags.v
// Purpose: sticky wake-up event flags
// Assumes: set and clear are single-cycle pulses on clk
// Notes: a set in the clear cycle wins
`default_nettype none
module wake_flags #(
  parameter N = 5
) (
  input wire clk,
  input wire rst_n,
  input wire [N-1:0] set,
  input wire clear,
  output reg [N-1:0] flags
);
  always @(posedge clk) begin
    if (!rst_n) begin
      flags <= {N{1'b0}};
    end else begin
      flags <= (clear ? {N{1'b0}} : flags) | set;
    end
  end
endmodule
`default_nettype wire

// ### sim/low_power_suspend_sleep_wake_tb.sv
// Purpose: self-checking bench of power_mode_ctrl
// Assumes: apb answers in the first access cycle
// Notes: wake events come from wake_src_model
`default_nettype none
`include "pm_defs.vh"
module low_power_suspend_sleep_wake_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
  logic two_cell_mode = 1'b0, pready, pslverr, rtc_osc_fail, rtc_alarm, port_match, cmp_out;
  logic rst_pin_n, clk_gate_off, osc_off, core_halt, regulator_off, ram_on_supply_pin;
  logic analog_tie_vbat, analog_float, io_hold, state_retain;
  logic [2:0] which = 3'h7;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int n_errors = 0, cmp_count = 0;
  wire [8:0] lp = {clk_gate_off, osc_off, core_halt, regulator_off, ram_on_supply_pin,
    io_hold, state_retain, analog_tie_vbat, analog_float};
  power_mode_ctrl dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rtc_osc_fail, .rtc_alarm, .port_match, .cmp_out, .rst_pin_n,
    .two_cell_mode, .clk_gate_off, .osc_off, .core_halt, .regulator_off, .ram_on_supply_pin,
    .analog_tie_vbat, .analog_float, .io_hold, .state_retain);
  wake_src_model src (.clk, .go, .which, .rtc_osc_fail, .rtc_alarm, .port_match, .cmp_out,
    .rst_pin_n);
  initial forever #50 clk = ~clk;
  task automatic summarize;
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // setup now, access next edge, hold until pready; psel stays up for back-to-back
  task automatic xfer(logic wr, logic [11:0] a, logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      n_errors++;
      summarize;
    end
    rd = prdata;
    penable <= 1'b0;
  endtask
  task automatic idle;
    psel <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fire(logic [2:0] w);
    which <= w;
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
  endtask
  // back-to-back flag reads across the wake edge
  task automatic wait_wake;
    for (int n = 0; n < 20 && clk_gate_off !== 1'b0; n++) xfer(1'b0, `PM_OFF_CFG, 32'h0);
    if (clk_gate_off !== 1'b0) begin
      n_errors++;
      summarize;
    end
    idle;
  endtask
  task automatic t_regs;
    xfer(1'b0, `PM_OFF_CFG, 32'h0);
    chk("cfg", 32'h0, rd);
    xfer(1'b0, 12'h00c, 32'h0);
    chk("pslverr", 32'h1, pslverr);
    idle;
    chk("outs", 32'h0, lp);
  endtask
  task automatic t_suspend;
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, `PM_OFF_CFG, 32'h60 | (32'h1 << s));
      idle;
      chk("suspend", 32'h1c0, lp);
      fire(3'((s + 1) % 4));
      repeat (8) @(posedge clk);
      chk("held", 32'h1, clk_gate_off);
      fire(3'(s));
      wait_wake;
      xfer(1'b0, `PM_OFF_CFG, 32'h0);
      idle;
      chk("flags", 32'h1 << s | 32'h1 << (s + 1) % 4, rd);
    end
  endtask
  task automatic t_refuse;
    fire(3'h1);
    repeat (6) @(posedge clk);
    xfer(1'b1, `PM_OFF_CFG, 32'h42);
    xfer(1'b0, `PM_OFF_STAT, 32'h0);
    idle;
    chk("refused", 32'h4, rd);
    chk("no entry", 32'h0, lp);
    xfer(1'b1, `PM_OFF_CFG, 32'h44);
    idle;
    chk("entered", 32'h1c0, lp);
    fire(3'h4);
    wait_wake;
    xfer(1'b0, `PM_OFF_CFG, 32'h0);
    idle;
    chk("rst flag", 32'h1b, rd);
    repeat (150) @(posedge clk);
  endtask
  task automatic t_sleep(logic f);
    xfer(1'b1, `PM_OFF_DCDC, {30'h0, f, 1'b0});
    xfer(1'b1, `PM_OFF_CFG, 32'ha3);
    idle;
    idle;
    chk("sleep", {7'h7f, !f, f}, lp);
    fire(3'h0);
    repeat (8) @(posedge clk);
    chk("one-cell", 32'h1, regulator_off);
    two_cell_mode <= f;
    fire(f ? 3'h0 : 3'h1);
    wait_wake;
    chk("awake", 32'h0, lp);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_suspend;
    t_refuse;
    t_sleep(1'b0);
    t_sleep(1'b1);
    summarize;
  end
endmodule
`default_nettype wire

// ### sim/pm_checker.sv
// Purpose: port checks of power_mode_ctrl
// Assumes: one clock, rst_n synchronous active low
// Notes: bound at the file foot
`default_nettype none
module pm_checker (
  input wire logic clk, rst_n, psel, penable, pwrite, pready, pslverr, rst_pin_n,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic clk_gate_off, osc_off, core_halt, regulator_off, ram_on_supply_pin,
  input wire logic analog_tie_vbat, analog_float, io_hold, state_retain
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire cfg_wr = psel && penable && pready && pwrite && paddr == 12'h000;
  logic susp_wr_reg, sleep_wr_reg;
  always @(posedge clk) begin
    susp_wr_reg <= cfg_wr && pwdata[6];
    sleep_wr_reg <= cfg_wr && pwdata[7];
  end
  sequence woke;
    $fell(clk_gate_off);
  endsequence
  sequence cfg_read;
    pready && !pwrite && paddr == 12'h000;
  endsequence
  a_suspend_halt: assert property (clk_gate_off |-> osc_off && core_halt)
    else $error("halt missing");
  a_sleep_power: assert property (regulator_off |->
    clk_gate_off && ram_on_supply_pin && io_hold && state_retain) else $error("sleep outs");
  a_rail_choice: assert property ((analog_tie_vbat || analog_float) == regulator_off
    && !(analog_tie_vbat && analog_float)) else $error("analog rail");
  a_suspend_cause: assert property ($rose(clk_gate_off) && !regulator_off |-> susp_wr_reg)
    else $error("suspend cause");
  a_sleep_cause: assert property ($rose(regulator_off) |-> sleep_wr_reg)
    else $error("sleep cause");
  a_reset_wake: assert property (clk_gate_off && $fell(rst_pin_n) |-> ##[1:6] !clk_gate_off)
    else $error("reset pin wake");
  a_wake_zero: assert property (woke ##[0:1] cfg_read |-> prdata[4:0] == 5'h00)
    else $error("flags after wake");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h008 || paddr[1:0] != 2'h0))
    else $error("slave error");
endmodule
bind power_mode_ctrl pm_checker u_pm_checker (.clk, .rst_n, .psel, .penable, .pwrite, .pready,
  .pslverr, .rst_pin_n, .paddr, .pwdata, .prdata, .clk_gate_off, .osc_off, .core_halt,
  .regulator_off, .ram_on_supply_pin, .analog_tie_vbat, .analog_float, .io_hold, .state_retain);
`default_nettype wire

// ### sim/wake_src_model.sv
// Purpose: far-side wake event sources, one-cycle pulses
// Assumes: go and which change just after a clk edge
// Notes: which 0 cmp, 1 port, 2 alarm, 3 osc fail, 4 reset pin
`default_nettype none
module wake_src_model (
  input wire logic clk, go,
  input wire logic [2:0] which,
  output logic rtc_osc_fail, rtc_alarm, port_match, cmp_out, rst_pin_n
);
  logic [2:0] sel_reg = 3'h7;
  always @(posedge clk) sel_reg <= go ? which : 3'h7;
  assign cmp_out = sel_reg == 3'h0;
  assign port_match = sel_reg == 3'h1;
  assign rtc_alarm = sel_reg == 3'h2;
  assign rtc_osc_fail = sel_reg == 3'h3;
  assign rst_pin_n = sel_reg != 3'h4;
endmodule
`default_nettype wire
